// File: hw/guard_consts.vh
/*
  Constants of the speed-bin timing guard: register map, field ranges,
  command codes and the timing limits in picoseconds.
  Assumes it is included by the guard module only.
*/
// ------------------------------------------------------------
// How it works
// - ACT to column access waits tRCD
// - bank open between 32 ns and 9 tREFI; past 9 tREFI the code only sets ras_err
// - ACT to ACT or REF waits tRC
// - DBI read latency only from allowed set
// - latency times clock must cover tAA
// - clock fits both CL and CWL bands
// - latency times clock within tAA max
// - reserved latency and clock pairs refused
// - optional values only when part supports
// - tables only with DLL on, no geardown
// - below 1600 MT/s use slow limits
// - refresh every 7.8 us, hot 3.9 us
// - DLL off clock between 8 and 20 ns
// - same group column gap max(5nCK,5 ns)
// - other group column gap 4 clocks
// ------------------------------------------------------------
`ifndef GUARD_CONSTS_VH
`define GUARD_CONSTS_VH

// register byte offsets
`define A_CTRL 8'h00
`define A_TCK 8'h04
`define A_CMD 8'h08
`define A_STAT 8'h0C

// control fields
`define F_CL 4:0
`define F_CWL 9:5
`define F_DBI 10
`define F_OPT 11
`define F_DLLOFF 12
`define F_GEAR 13
`define F_HOT 14
`define F_EN 15
`define CTRL_RST 16'h0000
`define TCK_RST 16'h0000

// command codes
`define C_ACT 3'h1
`define C_RD 3'h2
`define C_WR 3'h3
`define C_PRE 3'h4
`define C_REF 3'h5

// fast grade limits, ps
`define T_RCD 28'h0003750
`define T_RCD_OPT 28'h00035B6
`define T_RAS 28'h0007D00
`define T_RC 28'h000B450
`define T_RC_OPT 28'h000B2B6
// slow grade limits, ps
`define S_RCD 28'h00035B6
`define S_RCD_OPT 28'h00034BC
`define S_RAS 28'h00088B8
`define S_RC 28'h000BE6E
`define S_RC_OPT 28'h000BD74
// access time ceiling, ps
`define T_AA_MAX 20'h04650
// column spacing
`define T_CCDL 16'h1388
`define S_CCDL 16'h186A
`define N_CCDL 3'h5
`define N_CCDS 3'h4
// refresh interval, ps
`define T_REFI 28'h07704C0
`define T_REFI_HOT 28'h03B8260
// clock period bounds, ps
`define TCK_1600 16'h04E2
`define DLLOFF_MIN 16'h1F40
`define DLLOFF_MAX 16'h4E20
`define DBI_NCK 2'h3
`define SAT 28'hFFFFFFF

`endif

// File: hw/ddr4_speed_bin_timing_guard.v
/*
  Host-side timing guard for a 2400 MT/s DDR4 part. Software programs
  latencies, clock period and one pending command over APB; the guard
  holds the command until every per-bank and column limit is met, then
  drives it on the command pins. It also schedules refresh and checks
  read data arrival.
  Assumes a single 20 MHz clock; the link clock is made here by a
  divider, and the read-data flag from the part arrives asynchronously.
*/
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "guard_consts.vh"

module ddr4_speed_bin_timing_guard #(
  parameter CK_DIV = 4,
  parameter NBANK = 16
) (
  // clock and reset
  input wire sys_clk_in,
  input wire rst_in,
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  // memory command link
  output reg ck_out,
  output reg [2:0] cmd_out,
  output reg [3:0] bank_out,
  output reg cmd_valid_out,
  input wire rd_data_valid_in
);

  // ----------------------------------------------------------
  // registers and derived settings
  // ----------------------------------------------------------
  localparam integer DIV_LAST_I = CK_DIV - 1;
  localparam integer DIV_HALF_I = CK_DIV / 2;
  localparam [7:0] DIV_LAST = DIV_LAST_I[7:0];
  localparam [7:0] DIV_HALF = DIV_HALF_I[7:0];

  reg [15:0] ctrl;
  reg [15:0] tck;
  reg [2:0] p_cmd;
  reg [3:0] p_bank;
  reg busy;
  reg ras_err;
  reg lat_err;
  reg [7:0] div;
  wire tick = (div == DIV_LAST);
  wire [4:0] cl = ctrl[`F_CL];
  wire [4:0] cwl = ctrl[`F_CWL];
  wire dbi = ctrl[`F_DBI];
  wire opt = ctrl[`F_OPT];
  wire en = ctrl[`F_EN];
  wire [27:0] tck28 = {12'h000, tck};

  // slow grade limits below 1600 MT/s or with DLL off
  wire slow = (tck > `TCK_1600) | ctrl[`F_DLLOFF];
  // optional shorter figures only when the part allows
  wire [27:0] trcd = slow ? (opt ? `S_RCD_OPT : `S_RCD) :
                     (opt ? `T_RCD_OPT : `T_RCD);
  wire [27:0] tras = slow ? `S_RAS : `T_RAS;
  wire [27:0] trc = slow ? (opt ? `S_RC_OPT : `S_RC) :
                    (opt ? `T_RC_OPT : `T_RC);
  wire [15:0] tccdl = slow ? `S_CCDL : `T_CCDL;
  wire [27:0] trefi = ctrl[`F_HOT] ? `T_REFI_HOT : `T_REFI;
  // open limit is nine refresh intervals
  wire [31:0] ras_max = {4'h0, trefi} * 32'h9;

  // ----------------------------------------------------------
  // latency and clock legality
  // ----------------------------------------------------------
  wire [20:0] aa_ps = cl * tck;
  wire [4:0] rl_dbi = cl + ((cl >= 5'd15) ? 5'd3 : 5'd2);
  reg band;
  reg cw2;

  // clock period band for each CL at this speed bin
  always @* begin
    band = 1'b0;
    cw2 = 1'b0;
    case (cl)
      5'd9, 5'd10: begin
        cw2 = (cwl == 5'd9);
        band = cw2 & (tck >= 16'd1500) & (tck <= 16'd1600);
      end
      5'd11, 5'd12: begin
        cw2 = (cwl == 5'd9) | (cwl == 5'd11);
        band = cw2 & (tck >= 16'd1250) & (tck < 16'd1500);
      end
      5'd13, 5'd14: begin
        cw2 = (cwl == 5'd10) | (cwl == 5'd12);
        band = cw2 & (tck >= 16'd1071) & (tck < 16'd1250);
      end
      5'd15, 5'd16: begin
        cw2 = (cwl == 5'd11) | (cwl == 5'd14);
        band = cw2 & (tck >= 16'd938) & (tck < 16'd1071);
      end
      5'd17, 5'd18: begin
        cw2 = (cwl == 5'd12) | (cwl == 5'd16);
        band = cw2 & (tck >= 16'd833) & (tck < 16'd938);
      end
      default: begin
        band = 1'b0;
      end
    endcase
  end

  // optional rows need the support bit
  wire opt_row = (cl == 5'd11) | (cl == 5'd13) | (cl == 5'd15);
  wire opt_ok = ~opt_row | opt;
  wire aa_ok = ({7'h00, aa_ps} >= trcd) &
               ({7'h00, aa_ps} <= {8'h00, `T_AA_MAX});
  wire dbi_ok = ~dbi | ((rl_dbi >= 5'd12) & (rl_dbi <= 5'd21) &
                (rl_dbi != 5'd17));
  wire dll_ok = (tck >= `DLLOFF_MIN) & (tck <= `DLLOFF_MAX);
  wire cfg_ok = ctrl[`F_DLLOFF] ? dll_ok :
                (~ctrl[`F_GEAR] & band & aa_ok & opt_ok & dbi_ok);

  // ----------------------------------------------------------
  // per bank elapsed time since activate and precharge
  // ----------------------------------------------------------
  wire [NBANK-1:0] open_v;
  wire [NBANK-1:0] rcd_ok;
  wire [NBANK-1:0] ras_ok;
  wire [NBANK-1:0] rc_ok;
  wire [NBANK-1:0] rp_ok;
  wire [NBANK-1:0] over_v;
  wire go;
  wire [2:0] i_cmd;
  wire [3:0] i_bank;

  genvar b;
  generate
    for (b = 0; b < NBANK; b = b + 1) begin : g_bank
      reg [27:0] act_ps;
      reg [27:0] pre_ps;
      reg open;
      wire hit = go & (i_bank == b);
      // counts whole link clocks so limits round up; the
      // issuing clock itself counts as the first elapsed one
      always @(posedge sys_clk_in) begin
        if (rst_in) begin
          act_ps <= `SAT;
          pre_ps <= `SAT;
          open <= 1'b0;
        end else if (tick) begin
          if (hit & (i_cmd == `C_ACT)) begin
            act_ps <= tck28;
            open <= 1'b1;
          end else if (~&act_ps[27:24]) begin
            act_ps <= act_ps + tck28;
          end
          if (hit & (i_cmd == `C_PRE)) begin
            pre_ps <= tck28;
            open <= 1'b0;
          end else if (~&pre_ps[27:24]) begin
            pre_ps <= pre_ps + tck28;
          end
        end
      end
      assign open_v[b] = open;
      assign rcd_ok[b] = act_ps >= trcd;
      assign ras_ok[b] = act_ps >= tras;
      assign rc_ok[b] = act_ps >= trc;
      assign rp_ok[b] = pre_ps >= trcd;
      assign over_v[b] = open & ({4'h0, act_ps} >= ras_max);
    end
  endgenerate

  // ----------------------------------------------------------
  // column spacing and refresh interval
  // ----------------------------------------------------------
  reg [15:0] col_ps;
  reg [2:0] col_nck;
  reg [1:0] last_bg;
  reg [27:0] ref_ps;
  wire ref_due = en & (ref_ps >= trefi);
  wire col_ok = (p_bank[3:2] == last_bg) ?
                ((col_nck >= `N_CCDL) & (col_ps >= tccdl)) :
                (col_nck >= `N_CCDS);
  wire idle = ~|open_v & (&rc_ok) & (&rp_ok);

  // legality of the pending command at this instant
  reg legal;
  always @* begin
    case (p_cmd)
      `C_ACT: legal = ~open_v[p_bank] & rc_ok[p_bank] &
                      rp_ok[p_bank] & ~ref_due;
      `C_RD, `C_WR: legal = open_v[p_bank] & rcd_ok[p_bank] &
                            col_ok;
      `C_PRE: legal = ~open_v[p_bank] | ras_ok[p_bank];
      `C_REF: legal = idle;
      default: legal = 1'b0;
    endcase
  end

  // refresh takes priority over the software command
  wire go_ref = tick & ref_due & idle & cfg_ok;
  wire go_sw = tick & busy & legal & cfg_ok & en & ~go_ref;
  assign go = go_ref | go_sw;
  assign i_cmd = go_ref ? `C_REF : p_cmd;
  assign i_bank = go_ref ? 4'h0 : p_bank;
  wire is_col = go_sw & ((p_cmd == `C_RD) | (p_cmd == `C_WR));
  wire is_ref = go & (i_cmd == `C_REF);

  // column and refresh timers
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      col_ps <= 16'hFFFF;
      col_nck <= 3'h7;
      last_bg <= 2'h0;
      ref_ps <= 28'h0000000;
    end else if (tick) begin
      if (is_col) begin
        col_ps <= tck;
        col_nck <= 3'h1;
        last_bg <= p_bank[3:2];
      end else begin
        if (~&col_nck) col_nck <= col_nck + 3'h1;
        if ({1'b0, col_ps} + {1'b0, tck} <= 17'h0FFFF)
          col_ps <= col_ps + tck;
        else
          col_ps <= 16'hFFFF;
      end
      if (~en) ref_ps <= 28'h0000000;
      else if (is_ref) ref_ps <= tck28;
      else if (~&ref_ps[27:24]) ref_ps <= ref_ps + tck28;
    end
  end

  // ----------------------------------------------------------
  // link clock and command pins
  // ----------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      div <= 8'h00;
      ck_out <= 1'b0;
      cmd_out <= 3'h0;
      bank_out <= 4'h0;
      cmd_valid_out <= 1'b0;
    end else begin
      div <= tick ? 8'h00 : div + 8'h01;
      ck_out <= tick | ((div + 8'h01) < DIV_HALF);
      cmd_valid_out <= go;
      if (go) begin
        cmd_out <= i_cmd;
        bank_out <= i_bank;
      end
    end
  end

  // ----------------------------------------------------------
  // read data arrival check
  // ----------------------------------------------------------
  reg dv_s1;
  reg dv_s2;
  reg dv_s3;
  reg rd_pend;
  reg [19:0] rd_ps;
  wire [19:0] dbi_add = dbi ? ({4'h0, tck} * `DBI_NCK) : 20'h00000;
  wire [19:0] aa_lo = trcd[19:0] + dbi_add;
  wire [19:0] aa_hi = `T_AA_MAX + dbi_add;
  wire dv_rise = dv_s2 & ~dv_s3;
  wire early = dv_rise & rd_pend & (rd_ps < aa_lo);
  wire late = rd_pend & (rd_ps > aa_hi);

  // synchroniser, then edge against the timer
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      dv_s1 <= 1'b0;
      dv_s2 <= 1'b0;
      dv_s3 <= 1'b0;
      rd_pend <= 1'b0;
      rd_ps <= 20'h00000;
    end else begin
      dv_s1 <= rd_data_valid_in;
      dv_s2 <= dv_s1;
      dv_s3 <= dv_s2;
      if (is_col & (p_cmd == `C_RD)) begin
        rd_pend <= 1'b1;
        rd_ps <= 20'h00000;
      end else if (dv_rise | late) begin
        rd_pend <= 1'b0;
      end else if (tick & rd_pend) begin
        rd_ps <= rd_ps + {4'h0, tck};
      end
    end
  end

  // ----------------------------------------------------------
  // apb slave: zero wait, registered read data
  // ----------------------------------------------------------
  wire setup = psel_in & ~penable_in;
  wire acc = psel_in & penable_in;
  wire hit_a = (paddr_in == `A_CTRL) | (paddr_in == `A_TCK) |
               (paddr_in == `A_CMD) | (paddr_in == `A_STAT);
  wire bad_cmd = (pwdata_in[2:0] == 3'h0) | (pwdata_in[2:0] > `C_REF);
  wire cmd_no = pwrite_in & (paddr_in == `A_CMD) &
                (busy | ~cfg_ok | ~en | bad_cmd);
  wire wr = acc & pwrite_in & hit_a & ~cmd_no;
  wire clr_w = wr & (paddr_in == `A_STAT);
  assign pready_out = 1'b1;
  assign pslverr_out = acc & (~hit_a | cmd_no);

  // register writes; sticky flags let the set win
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctrl <= `CTRL_RST;
      tck <= `TCK_RST;
      p_cmd <= 3'h0;
      p_bank <= 4'h0;
      busy <= 1'b0;
      ras_err <= 1'b0;
      lat_err <= 1'b0;
    end else begin
      if (wr & (paddr_in == `A_CTRL)) ctrl <= pwdata_in[15:0];
      if (wr & (paddr_in == `A_TCK)) tck <= pwdata_in[15:0];
      if (wr & (paddr_in == `A_CMD)) begin
        p_cmd <= pwdata_in[2:0];
        p_bank <= pwdata_in[7:4];
        busy <= 1'b1;
      end else if (go_sw) begin
        busy <= 1'b0;
      end
      ras_err <= (|over_v) | (ras_err & ~(clr_w & pwdata_in[2]));
      lat_err <= early | late | (lat_err & ~(clr_w & pwdata_in[3]));
    end
  end

  // read data captured in the setup cycle
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      prdata_out <= 32'h00000000;
    end else if (setup & ~pwrite_in) begin
      case (paddr_in)
        `A_CTRL: prdata_out <= {16'h0000, ctrl};
        `A_TCK: prdata_out <= {16'h0000, tck};
        `A_CMD: prdata_out <= {24'h000000, p_bank, 1'b0, p_cmd};
        `A_STAT: prdata_out <= {open_v, 10'h000, rd_pend, ref_due,
                                lat_err, ras_err, cfg_ok, busy};
        default: prdata_out <= 32'h00000000;
      endcase
    end
  end

endmodule

// File: test/guard_checker_properties.sv
/* Checker of command spacing on the guard's link pins.
   Assumes the bench's 833 ps link period for the tick limits. */
`timescale 1ns/1ps
module guard_checker #(
  parameter CK_DIV = 4,
  parameter RCD_T = 17,
  parameter RAS_T = 39,
  parameter RC_T = 56,
  parameter CCDL_T = 7
) (
  // clock, reset and command pins
  input wire sys_clk_in,
  input wire rst_in,
  input wire ck_out,
  input wire [2:0] cmd_out,
  input wire [3:0] bank_out,
  input wire cmd_valid_out
);
  // ------------------------------------------------
  // cycles since last activate and last column command
  // ------------------------------------------------
  wire act = cmd_valid_out && cmd_out == 3'h1;
  wire col = cmd_valid_out && (cmd_out == 3'h2 || cmd_out == 3'h3);
  wire pre = cmd_valid_out && cmd_out == 3'h4;
  wire refr = cmd_valid_out && cmd_out == 3'h5;
  reg [11:0] act_cnt;
  reg [11:0] col_cnt;
  reg [3:0] act_bank;
  reg [1:0] col_grp;
  // counters saturate so an old event never wraps into a fault
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      act_cnt <= 12'hFFF;
      col_cnt <= 12'hFFF;
      act_bank <= 4'h0;
      col_grp <= 2'h0;
    end else begin
      act_cnt <= act ? 12'h001 : act_cnt + {11'h0, act_cnt != 12'hFFF};
      col_cnt <= col ? 12'h001 : col_cnt + {11'h0, col_cnt != 12'hFFF};
      if (act)
        act_bank <= bank_out;
      if (col)
        col_grp <= bank_out[3:2];
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_rcd_wait: assert property (
    col && bank_out == act_bank |-> act_cnt >= RCD_T * CK_DIV)
    else $error("column too soon after activate");
  a_ras_wait: assert property (
    pre && bank_out == act_bank |-> act_cnt >= RAS_T * CK_DIV)
    else $error("precharge too soon after activate");
  a_rc_wait: assert property (
    (act && bank_out == act_bank) || refr |-> act_cnt >= RC_T * CK_DIV)
    else $error("activate or refresh too soon");
  a_ccd_same: assert property (
    col && bank_out[3:2] == col_grp |-> col_cnt >= CCDL_T * CK_DIV)
    else $error("same group column gap short");
  a_ccd_other: assert property (
    col |-> col_cnt >= 4 * CK_DIV)
    else $error("column gap short");
  a_cmd_tick: assert property (
    cmd_valid_out |-> ck_out && !$past(ck_out))
    else $error("command off link clock rise");
  a_valid_gap: assert property (
    cmd_valid_out |=> !cmd_valid_out [*3])
    else $error("commands closer than one tick");
  a_cmd_hold: assert property (
    !cmd_valid_out |-> $stable(cmd_out) && $stable(bank_out))
    else $error("command pins moved without valid");
  // main scenarios reached
  cover property (col && bank_out[3:2] == col_grp);
  cover property (refr);
  cover property (pre);
endmodule
bind ddr4_speed_bin_timing_guard guard_checker #(.CK_DIV(CK_DIV))
  guard_checker_i (.sys_clk_in, .rst_in, .ck_out, .cmd_out, .bank_out,
  .cmd_valid_out);

// File: test/ddr4_part_model.sv
/* Memory part model: raises the read data flag a chosen number of
   link clocks after each read. Assumes host clock sampling. */
`timescale 1ns/1ps
module ddr4_part_model (
  // sampling clock
  input wire sys_clk_in,
  // command pins and latency choice
  input wire ck_in,
  input wire cmd_valid_in,
  input wire [2:0] cmd_in,
  input wire [4:0] lat_in,
  // read data flag
  output wire rd_data_valid_out
);
  reg ck_q = 1'b0;
  reg [31:0] pipe = 32'h0;
  // flag follows the read by lat_in link clocks
  assign rd_data_valid_out = pipe[lat_in];
  // shift reads along on every link clock rise
  always @(posedge sys_clk_in) begin
    ck_q <= ck_in;
    if (ck_in && !ck_q)
      pipe <= {pipe[30:0], cmd_valid_in && cmd_in == 3'h2};
  end
endmodule

// File: test/ddr4_speed_bin_timing_guard_bench.sv
/* Bench of the timing guard: registers, command spacing, read latency
   window and refresh interval. Assumes the part model and checker. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done = checks_done + 1; \
  if ((s) !== (e)) begin err_total = err_total + 1; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module ddr4_speed_bin_timing_guard_bench;
  // ------------------------------
  // signals and tables
  // ------------------------------
  localparam TCK = 833;
  reg sys_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg psel_in = 1'b0;
  reg penable_in = 1'b0;
  reg pwrite_in = 1'b0;
  reg [7:0] paddr_in = 8'h00;
  reg [31:0] pwdata_in = 32'h0;
  reg [4:0] lat = 5'h11;
  reg [31:0] rdat;
  reg serr;
  reg [3:0] b;
  reg [32:0] cfg [0:9];
  reg [6:0] rt [0:3];
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, ck_out, cmd_valid_out, rd_data_valid_in;
  wire [2:0] cmd_out;
  wire [3:0] bank_out;
  integer err_total = 0;
  integer checks_done = 0;
  integer cyc = 0;
  integer seed = 32'h57A94F4F;
  integer i, t0, t1, t2;
  ddr4_speed_bin_timing_guard ddr4_speed_bin_timing_guard_i (.sys_clk_in,
    .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .ck_out, .cmd_out, .bank_out,
    .cmd_valid_out, .rd_data_valid_in);
  ddr4_part_model ddr4_part_model_i (.sys_clk_in, .ck_in(ck_out),
    .cmd_valid_in(cmd_valid_out), .cmd_in(cmd_out), .lat_in(lat),
    .rd_data_valid_out(rd_data_valid_in));
  // clock and hang limit
  always #25 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end
  // limit in ps to host cycles at four per link clock
  function integer cyc_of(input integer ps);
    cyc_of = (ps + TCK - 1) / TCK * 4;
  endfunction
  // one apb transfer, held until pready
  task apb(input reg wr, input reg [7:0] a, input reg [31:0] d);
    begin
      @(posedge sys_clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      @(posedge sys_clk_in);
      while (pready_out !== 1'b1) @(posedge sys_clk_in);
      rdat = prdata_out;
      serr = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask
  // wait for a command on the pins, stamp its cycle
  task w(input reg [2:0] c, output integer t);
    begin
      @(posedge sys_clk_in);
      while (!(cmd_valid_out === 1'b1 && cmd_out === c))
        @(posedge sys_clk_in);
      t = cyc;
    end
  endtask
  task cmd(input reg [2:0] c, input reg [3:0] bk, output integer t);
    begin
      apb(1'b1, 8'h08, {24'h0, bk, 1'b0, c});
      w(c, t);
      `CHK("bank pins", bk, bank_out)
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    cfg[0] = {16'h8211, 16'h0341, 1'b1};
    cfg[1] = {16'h8210, 16'h0341, 1'b0};
    cfg[2] = {16'h81D0, 16'h03AA, 1'b1};
    cfg[3] = {16'h81CF, 16'h042F, 1'b0};
    cfg[4] = {16'h8929, 16'h05DC, 1'b1};
    cfg[5] = {16'h8129, 16'h05DC, 1'b0};
    cfg[6] = {16'h9211, 16'h1F40, 1'b1};
    cfg[7] = {16'h9211, 16'h1F3F, 1'b0};
    cfg[8] = {16'hA211, 16'h0341, 1'b0};
    cfg[9] = {16'h8D29, 16'h05DC, 1'b0};
    rt[0] = {1'b0, 5'h11, 1'b0};
    rt[1] = {1'b0, 5'h16, 1'b1};
    rt[2] = {1'b1, 5'h16, 1'b0};
    rt[3] = {1'b1, 5'h11, 1'b1};
    b = $random(seed);
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl reset", 32'h0, rdat)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped err", 1'b1, serr)
    apb(1'b1, 8'h08, 32'h1);
    `CHK("cmd refused", 1'b1, serr)
    $display("done reset");
    for (i = 0; i < 10; i = i + 1) begin
      apb(1'b1, 8'h00, {16'h0, cfg[i][32:17]});
      apb(1'b1, 8'h04, {16'h0, cfg[i][16:1]});
      apb(1'b0, 8'h0C, 32'h0);
      `CHK("cfg ok", cfg[i][0], rdat[1])
    end
    apb(1'b1, 8'h00, 32'hC211);
    apb(1'b1, 8'h04, 32'h341);
    $display("done config");
    cmd(3'h1, b, t0);
    apb(1'b1, 8'h08, {24'h0, b, 4'h2});
    apb(1'b1, 8'h08, {24'h0, b, 4'h4});
    `CHK("busy refuse", 1'b1, serr)
    w(3'h2, t1);
    `CHK("act to rd", cyc_of(14160), t1 - t0)
    cmd(3'h4, b, t1);
    `CHK("act to pre", cyc_of(32000), t1 - t0)
    cmd(3'h1, b, t2);
    `CHK("act to act", cyc_of(46160), t2 - t0)
    `CHK("pre to act", cyc_of(14160), t2 - t1)
    cmd(3'h1, b ^ 4'h4, t0);
    cmd(3'h2, b, t0);
    cmd(3'h2, b, t1);
    `CHK("same group gap", cyc_of(5000), t1 - t0)
    cmd(3'h2, b ^ 4'h4, t2);
    `CHK("other group gap", 16, t2 - t1)
    $display("done timing");
    // let earlier read flags drain out of the part model
    repeat (150) @(posedge sys_clk_in);
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 8'h00, 32'hC211 | {21'h0, rt[i][6], 10'h0});
      apb(1'b1, 8'h0C, 32'h8);
      lat <= rt[i][5:1];
      cmd(3'h2, b, t0);
      repeat (120) @(posedge sys_clk_in);
      apb(1'b0, 8'h0C, 32'h0);
      `CHK("latency err", rt[i][0], rdat[3])
    end
    $display("done latency");
    cmd(3'h4, b, t0);
    cmd(3'h4, b ^ 4'h4, t0);
    w(3'h5, t1);
    w(3'h5, t2);
    t0 = t2 - t1 - cyc_of(3900000);
    `CHK("refresh gap", 1'b1, t0 <= 8 && t0 >= -8)
    $display("done refresh");
    end_sim;
  end
endmodule
